// File: src/i2ces_regs.svh
// Register offsets, field positions, reset values and tags of the I2C error/no-stop status block
`ifndef I2CES_REGS_SVH
`define I2CES_REGS_SVH

// Register byte offsets
`define I2CES_OFS_RAW_STATUS 6'h00
`define I2CES_OFS_CLEAR 6'h04
`define I2CES_OFS_MASK 6'h08
`define I2CES_OFS_MCMD 6'h0C
`define I2CES_OFS_XSTATUS 6'h10

// Raw status bit positions
`define I2CES_BIT_RFS 16
`define I2CES_BIT_WTS 18
`define I2CES_BIT_ARB 24
`define I2CES_BIT_BUS_ERROR_FLAG 25
`define I2CES_BIT_MASTER_DONE_NO_STOP_FLAG 28
`define I2CES_STATUS_IMPL 32'h1305_0000

// Master command fields
`define I2CES_MCMD_GO 0
`define I2CES_MCMD_READ 1
`define I2CES_MCMD_STOP 2

// Error tags of the transaction status word
`define I2CES_TAG_NONE 4'h0
`define I2CES_TAG_ARB 4'h1
`define I2CES_TAG_BUS_ERROR_FLAG 4'h2

// Reset values
`define I2CES_RST_WORD 32'h0000_0000

`endif

// File: src/i2ces_pkg.sv
// Types shared by the I2C error/no-stop status block
package i2ces_pkg;

    // One bus word
    typedef logic [31:0] i2ces_word_t;

    // Master command as software programs it
    typedef struct packed {
        logic stop;
        logic rd;
        logic go;
    } i2ces_cmd_s;

    // Transaction status word contents
    typedef struct packed {
        logic last_stop;
        logic last_rd;
        logic [3:0] tag;
    } i2ces_xstat_s;

    // Master sequencing states
    typedef enum logic [1:0] {
        M_IDLE,
        M_BUSY,
        M_HOLD,
        M_WAIT_STOP
    } i2ces_mstate_e;

endpackage

// File: src/i2ces_top.sv
// Raw status, clear, mask and master sequencing for bus-error and no-stop flags
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "i2ces_regs.svh"

module i2ces_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq,
    // I2C pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    // Shift engine side, same clock
    input wire logic xact_active,
    input wire logic master_op_done,
    input wire logic arb_lost,
    input wire logic target_op_start,
    input wire logic target_op_rd,
    output logic master_start,
    output logic master_rd,
    output logic stop_issue,
    output logic stop_permit,
    output logic bus_release
);

    // Synchronisers for the pins, plus one stage of history for edges
    logic scl_s1_q, scl_s2_q, scl_prev_q;
    logic sda_s1_q, sda_s2_q, sda_prev_q;

    // Bus slave state
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;

    // Software visible registers
    i2ces_pkg::i2ces_word_t status_q, status_d;
    i2ces_pkg::i2ces_word_t mask_q, mask_d;
    i2ces_pkg::i2ces_cmd_s cmd_q, cmd_d;
    i2ces_pkg::i2ces_xstat_s xstat_q, xstat_d;

    // Master sequencing
    i2ces_pkg::i2ces_mstate_e mst_q, mst_d;

    // Deferred target operation
    logic tgt_pend_q, tgt_pend_d;
    logic tgt_rd_q, tgt_rd_d;

    // Registered outputs
    logic irq_d, scl_oe_d;
    logic start_q, start_d, stop_q, stop_d;
    logic permit_q, permit_d, release_q, release_d;

    // Clock pin synchroniser chain; the first stage feeds only the second
    // Reset to the idle high level, so no false edge follows reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_prev_q <= scl_s2_q;
        end
    end

    // Data pin synchroniser chain, same depth so both lines line up in time
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_prev_q <= sda_s2_q;
        end
    end

    // Start and stop conditions: data moves while the clock stays high
    wire scl_high = scl_s2_q & scl_prev_q;
    wire start_seen = scl_high & sda_prev_q & ~sda_s2_q;
    wire stop_seen = scl_high & ~sda_prev_q & sda_s2_q;
    wire bus_err = xact_active & (start_seen | stop_seen);

    // Bus decode; a write lands on the edge where the master sees ack
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire wr_fire = bus_req & wb_we_i & ack_q;
    wire [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wr_bits = wb_dat_i & sel_mask;
    wire hit_status = wb_adr_i == `I2CES_OFS_RAW_STATUS;
    wire hit_clear = wb_adr_i == `I2CES_OFS_CLEAR;
    wire hit_mask = wb_adr_i == `I2CES_OFS_MASK;
    wire hit_mcmd = wb_adr_i == `I2CES_OFS_MCMD;
    wire hit_xstat = wb_adr_i == `I2CES_OFS_XSTATUS;
    wire wr_clear = wr_fire & hit_clear;
    wire wr_mask = wr_fire & hit_mask;
    wire wr_mcmd = wr_fire & hit_mcmd & wb_sel_i[0];

    // Clear vector: writing one clears, only on implemented bits
    wire [31:0] clr_vec = wr_clear ? (wr_bits & `I2CES_STATUS_IMPL) : 32'h0000_0000;

    // No-stop flag as currently held
    wire nostop = status_q[`I2CES_BIT_MASTER_DONE_NO_STOP_FLAG];

    // Command accepted only in idle with the no-stop flag clear
    wire cmd_go = wr_mcmd & wb_dat_i[`I2CES_MCMD_GO];
    wire cmd_take = cmd_go & (mst_q == i2ces_pkg::M_IDLE) & ~nostop;

    // Master finishing, split by whether a stop was programmed
    wire m_done = (mst_q == i2ces_pkg::M_BUSY) & master_op_done;
    wire done_stop = m_done & cmd_q.stop;
    wire done_nostop = m_done & ~cmd_q.stop;
    wire m_arb = (mst_q == i2ces_pkg::M_BUSY) & arb_lost;
    wire retry_go = (mst_q == i2ces_pkg::M_WAIT_STOP) & stop_seen;

    // Target request released once the no-stop flag is clear
    wire tgt_new = target_op_start & ~tgt_pend_q;
    wire tgt_release = tgt_pend_q & ~nostop;

    // Events that set raw status bits
    logic [31:0] set_vec;
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[`I2CES_BIT_BUS_ERROR_FLAG] = bus_err;
        set_vec[`I2CES_BIT_ARB] = m_arb;
        set_vec[`I2CES_BIT_MASTER_DONE_NO_STOP_FLAG] = done_nostop;
        set_vec[`I2CES_BIT_WTS] = tgt_release & ~tgt_rd_q;
        set_vec[`I2CES_BIT_RFS] = tgt_release & tgt_rd_q;
    end

    // Sticky flags; a new event beats a clear in the same cycle
    assign status_d = ((status_q & ~clr_vec) | set_vec) & `I2CES_STATUS_IMPL;

    // Mask register honours byte enables
    assign mask_d = wr_mask ? ((mask_q & ~sel_mask) | wr_bits) & `I2CES_STATUS_IMPL : mask_q;

    // Command register keeps the latest accepted command
    assign cmd_d = cmd_take ? {wb_dat_i[`I2CES_MCMD_STOP], wb_dat_i[`I2CES_MCMD_READ], 1'b1}
                            : (m_done ? {cmd_q.stop, cmd_q.rd, 1'b0} : cmd_q);

    // Transaction status word; error tag written on each fault
    always_comb begin
        xstat_d = xstat_q;
        if (cmd_take) begin
            xstat_d.tag = `I2CES_TAG_NONE;
            xstat_d.last_rd = wb_dat_i[`I2CES_MCMD_READ];
            xstat_d.last_stop = wb_dat_i[`I2CES_MCMD_STOP];
        end
        if (m_arb) begin
            xstat_d.tag = `I2CES_TAG_ARB;
        end
        if (bus_err) begin
            xstat_d.tag = `I2CES_TAG_BUS_ERROR_FLAG;
        end
    end

    // Master sequencing: bus error aborts, arbitration loss waits for a stop
    always_comb begin
        mst_d = mst_q;
        case (mst_q)
            i2ces_pkg::M_IDLE: begin
                if (cmd_take) begin
                    mst_d = i2ces_pkg::M_BUSY;
                end
            end
            i2ces_pkg::M_BUSY: begin
                if (bus_err) begin
                    mst_d = i2ces_pkg::M_IDLE;
                end else if (m_arb) begin
                    mst_d = i2ces_pkg::M_WAIT_STOP;
                end else if (done_nostop) begin
                    mst_d = i2ces_pkg::M_HOLD;
                end else if (done_stop) begin
                    mst_d = i2ces_pkg::M_IDLE;
                end
            end
            i2ces_pkg::M_HOLD: begin
                // Bus stays owned until software acknowledges
                if (!status_d[`I2CES_BIT_MASTER_DONE_NO_STOP_FLAG]) begin
                    mst_d = i2ces_pkg::M_IDLE;
                end
            end
            i2ces_pkg::M_WAIT_STOP: begin
                if (retry_go) begin
                    mst_d = i2ces_pkg::M_BUSY;
                end
            end
            default: begin
                mst_d = i2ces_pkg::M_IDLE;
            end
        endcase
    end

    // Target operation is parked while the no-stop flag stands
    assign tgt_pend_d = tgt_new ? 1'b1 : (tgt_release ? 1'b0 : tgt_pend_q);
    assign tgt_rd_d = tgt_new ? target_op_rd : tgt_rd_q;

    // Clock stretch while a parked target operation waits
    assign scl_oe_d = tgt_pend_d & status_d[`I2CES_BIT_MASTER_DONE_NO_STOP_FLAG];

    // Engine strobes: start on accept or retry, stop only when programmed
    assign start_d = cmd_take | retry_go;
    assign stop_d = done_stop & ~nostop;
    assign permit_d = ~status_d[`I2CES_BIT_MASTER_DONE_NO_STOP_FLAG];
    assign release_d = mst_d == i2ces_pkg::M_WAIT_STOP;

    // Level interrupt from masked sticky status
    assign irq_d = |(status_d & mask_d);

    // Read data mux; unmapped offsets read zero
    wire [31:0] xstat_word = {26'h000_0000, xstat_q};
    wire [31:0] mcmd_word = {29'h0000_0000, cmd_q};
    assign rdat_d = hit_status ? status_q :
                    hit_mask ? mask_q :
                    hit_mcmd ? mcmd_word :
                    hit_xstat ? xstat_word : 32'h0000_0000;

    // Ack one cycle after the request, dropped the cycle after
    assign ack_d = bus_req & ~ack_q;

    // Bus slave flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            rdat_q <= `I2CES_RST_WORD;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // Raw status flags; reset clears every flag
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            status_q <= `I2CES_RST_WORD;
        end else begin
            status_q <= status_d;
        end
    end

    // Interrupt mask; all sources start masked so reset raises no interrupt
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mask_q <= `I2CES_RST_WORD;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Last accepted command; its busy bit drops when the engine reports done
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cmd_q <= 3'h0;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    // Transaction status word, loaded when a command is accepted; the tag is rewritten on each fault
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            xstat_q <= 6'h00;
        end else begin
            xstat_q <= xstat_d;
        end
    end

    // Sequencer and parked target flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mst_q <= i2ces_pkg::M_IDLE;
            tgt_pend_q <= 1'b0;
            tgt_rd_q <= 1'b0;
        end else begin
            mst_q <= mst_d;
            tgt_pend_q <= tgt_pend_d;
            tgt_rd_q <= tgt_rd_d;
        end
    end

    // Interrupt and stretch outputs; every top output comes straight from a flop
    // Stretch resets off so a reset never leaves the bus clock held low
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            irq <= irq_d;
            scl_oe <= scl_oe_d;
        end
    end

    // Engine strobes, one-cycle pulses
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            start_q <= start_d;
            stop_q <= stop_d;
        end
    end

    // Stop permission and bus release; no flag can stand after reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            permit_q <= 1'b1;
            release_q <= 1'b0;
        end else begin
            permit_q <= permit_d;
            release_q <= release_d;
        end
    end

    // Stretching only ever pulls low, so the driven level is a constant
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            scl_o <= 1'b0;
            master_rd <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            master_rd <= cmd_d.rd;
        end
    end

    // Output wiring from the flops above
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign master_start = start_q;
    assign stop_issue = stop_q;
    assign stop_permit = permit_q;
    assign bus_release = release_q;

endmodule

// File: src/i2ces_top_fix.sv
// (intentionally empty)

// File: verification/i2ces_peer.sv
// I2C peer that makes start and stop conditions on the bus
`timescale 1ns/1ps
module i2ces_peer (
    // Clock and stretch
    input wire logic sys_clk,
    input wire logic scl_oe,
    // Wired bus levels
    output logic scl_i,
    output logic sda_i
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    // Pull-ups: a line is high unless some party pulls it low
    assign scl_i = scl_q & ~scl_oe;
    assign sda_i = sda_q;
    // Four clocks a step leave room for the pin synchronisers
    task automatic step(input logic c, input logic d);
        repeat (4) @(posedge sys_clk);
        scl_q <= c;
        sda_q <= d;
    endtask
    // Stop: data rises with clock high; start: data falls with clock high
    task automatic cond(input logic stop);
        if (stop) begin
            step(1'b0, 1'b0);
            step(1'b1, 1'b0);
            step(1'b1, 1'b1);
        end else begin
            step(1'b1, 1'b0);
            step(1'b0, 1'b0);
            step(1'b0, 1'b1);
            step(1'b1, 1'b1);
        end
    endtask
endmodule

// File: verification/i2ces_properties.sv
// Port-level checks of the status and sequencing block
`timescale 1ns/1ps
module i2ces_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Inputs
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic master_op_done,
    input wire logic arb_lost,
    // Outputs
    input wire logic wb_ack_o,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic master_start,
    input wire logic stop_issue,
    input wire logic stop_permit,
    input wire logic bus_release
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Bus handshake and start strobe timing
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_latency: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
        else $error("ack late");
    a_start_pulse: assert property (master_start |=> !master_start) else $error("start long");
    // Flag gating of stop, commands and stretching
    a_scl_low: assert property (scl_o == 1'b0) else $error("clock driven high");
    a_stop_held: assert property (!stop_permit |-> !stop_issue)
        else $error("stop while flag set");
    a_flag_error_tag_a: assert property ($fell(stop_permit) |-> $past(master_op_done))
        else $error("flag without done");
    a_cmd_blocked: assert property (!stop_permit |-> !master_start)
        else $error("start while flag set");
    a_stretch_flag: assert property (scl_oe |-> !stop_permit)
        else $error("stretch without flag");
    a_stretch_end: assert property ($fell(scl_oe) |-> stop_permit)
        else $error("stretch end early");
    // Arbitration loss and retry
    a_release_error_tag_a: assert property ($rose(bus_release) |-> $past(arb_lost))
        else $error("release without loss");
    a_retry_start: assert property ($fell(bus_release) |-> master_start)
        else $error("no retry");
endmodule

// File: verification/i2ces_tb_top.sv
// Register-level tests of the bus-error and no-stop block
`timescale 1ns/1ps
module i2ces_tb_top;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, irq, scl_i, scl_o, scl_oe, sda_i;
    logic xact_active = 1'b0, master_op_done = 1'b0, arb_lost = 1'b0;
    logic target_op_start = 1'b0, target_op_rd = 1'b0;
    logic master_start, master_rd, stop_issue, stop_permit, bus_release;
    int error_cnt = 0;
    int checks_done = 0;
    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    i2ces_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
        .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
        .xact_active(xact_active), .master_op_done(master_op_done), .arb_lost(arb_lost),
        .target_op_start(target_op_start), .target_op_rd(target_op_rd),
        .master_start(master_start), .master_rd(master_rd), .stop_issue(stop_issue),
        .stop_permit(stop_permit), .bus_release(bus_release));
    i2ces_peer peer (.sys_clk(sys_clk), .scl_oe(scl_oe), .scl_i(scl_i), .sda_i(sda_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic pulse(input logic done, input logic lost);
        @(posedge sys_clk);
        master_op_done <= done;
        arb_lost <= lost;
        @(posedge sys_clk);
        master_op_done <= 1'b0;
        arb_lost <= 1'b0;
    endtask
    task automatic wait_start();
        do @(posedge sys_clk); while (master_start !== 1'b1);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk(6'h00, 32'h0);
        rchk(6'h3C, 32'h0);
        wb(1'b1, 6'h08, 32'hFFFF_FFFF);
        rchk(6'h08, 32'h1305_0000);
        wb(1'b1, 6'h08, 32'h1000_0000);
        rchk(6'h08, 32'h1000_0000);
        $display("test reset done");
        // Done without stop, then refused command and parked target
        wb(1'b1, 6'h0C, 32'h1);
        wait_start();
        pulse(1'b1, 1'b0);
        rchk(6'h00, 32'h1000_0000);
        chk(32'(stop_permit), 32'h0);
        chk(32'(irq), 32'h1);
        wb(1'b0, 6'h10, 32'h0);
        chk(rd & 32'hF, 32'h0);
        wb(1'b1, 6'h0C, 32'h1);
        @(posedge sys_clk);
        chk(32'(master_start), 32'h0);
        target_op_start <= 1'b1;
        @(posedge sys_clk);
        target_op_start <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(32'(scl_i), 32'h0);
        rchk(6'h00, 32'h1000_0000);
        wb(1'b1, 6'h08, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        wb(1'b1, 6'h04, 32'h1000_0000);
        rchk(6'h00, 32'h0004_0000);
        chk(32'(scl_oe), 32'h0);
        wb(1'b1, 6'h04, 32'h0004_0000);
        $display("test no-stop done");
        // Read with stop requested
        wb(1'b1, 6'h0C, 32'h7);
        wait_start();
        chk(32'(master_rd), 32'h1);
        pulse(1'b1, 1'b0);
        @(posedge sys_clk);
        chk(32'(stop_issue), 32'h1);
        rchk(6'h00, 32'h0);
        $display("test stop done");
        // Start condition in mid-transaction
        wb(1'b1, 6'h0C, 32'h5);
        wait_start();
        xact_active <= 1'b1;
        peer.cond(1'b0);
        repeat (8) @(posedge sys_clk);
        xact_active <= 1'b0;
        rchk(6'h00, 32'h0200_0000);
        wb(1'b0, 6'h10, 32'h0);
        chk(rd & 32'hF, 32'h2);
        rchk(6'h00, 32'h0200_0000);
        wb(1'b1, 6'h04, 32'h0200_0000);
        rchk(6'h00, 32'h0);
        $display("test bus error done");
        // Arbitration loss, stop on the bus, retry
        wb(1'b1, 6'h0C, 32'h5);
        wait_start();
        pulse(1'b0, 1'b1);
        @(posedge sys_clk);
        chk(32'(bus_release), 32'h1);
        wb(1'b0, 6'h10, 32'h0);
        chk(rd & 32'hF, 32'h1);
        rchk(6'h00, 32'h0100_0000);
        peer.cond(1'b1);
        wait_start();
        chk(32'(bus_release), 32'h0);
        pulse(1'b1, 1'b0);
        wb(1'b1, 6'h04, 32'h0100_0000);
        rchk(6'h00, 32'h0);
        $display("test arbitration done");
        // Reset in mid-run with the no-stop flag standing, then a target read
        wb(1'b1, 6'h0C, 32'h1);
        wait_start();
        pulse(1'b1, 1'b0);
        @(posedge sys_clk);
        chk(32'(stop_permit), 32'h0);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk(32'(stop_permit), 32'h1);
        rchk(6'h00, 32'h0);
        target_op_rd <= 1'b1;
        target_op_start <= 1'b1;
        @(posedge sys_clk);
        target_op_start <= 1'b0;
        rchk(6'h00, 32'h0001_0000);
        wb(1'b1, 6'h04, 32'h0001_0000);
        rchk(6'h00, 32'h0);
        $display("test mid reset done");
        stop_test();
    end
endmodule
bind i2ces_top i2ces_properties chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .master_op_done(master_op_done),
    .arb_lost(arb_lost), .wb_ack_o(wb_ack_o), .scl_o(scl_o), .scl_oe(scl_oe),
    .master_start(master_start), .stop_issue(stop_issue), .stop_permit(stop_permit),
    .bus_release(bus_release));
